//--- src/ntcd_decode.sv
`timescale 1ns/1ps
`include "ntcd_cfg.svh"

// Notes on behaviour
// - Group 001, byte FF is cosine; up to 779 cycles.
// - Group 001, byte F2 is partial tangent of stack top.
// - Group 001, byte F3 is partial arctangent; 494 cycles.
// - Group 001, byte FE is sine; up to 778 cycles.
// - Group 001, byte FB is sine and cosine; up to 816 cycles.
// - Sine, cosine and sine-cosine may take 78 more cycles for large operands.
// - Group 011, byte E3 reinitialises in 25 cycles.
// - Group 011, byte E4 enters protected mode in 12 cycles.
// - Group 011, byte F4 returns to real mode in 12 cycles.
// - Group 111, byte E0 stores status to accumulator; 18 cycles.
// - Group 001, reg 101 loads control word; 33 cycles.
// - Group 011, byte E2 clears exceptions in 8 cycles.
// - Group 001 reg 110 stores env 193; reg 100 loads env 85.
// - Group 101 reg 100 restores 396; reg 110 saves 522.
// - Group 001 F7 increments pointer 28; F6 decrements 29.
// - Group 001, byte D0 is no-op for 19 cycles.
// - Exceptions reach the host on a dedicated error output.
// - Legacy interrupt enable/disable opcodes change nothing.
// - Saved address is that of the first prefix byte.
// - Protected mode saves no opcode in the pointer image.

module ntcd_decode (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_instr_valid,
  input  wire ntcd_pkg::ntcd_instr_s i_instr,
  input  wire logic                  i_exc_raise,
  output logic                       o_busy,
  output logic                       o_error,
  output logic                       o_protected,
  output logic                       o_done,
  output ntcd_pkg::ntcd_op_e         o_op,
  output ntcd_pkg::ntcd_ptr_s        o_ptr,
  output logic [2:0]                 o_stack_ptr
);

  ntcd_pkg::ntcd_state_e state_r;
  ntcd_pkg::ntcd_op_e    dec_op;
  logic [9:0]            rom_cycles;
  logic [9:0]            cnt_r;
  logic                  load_r;
  logic                  accept;
  logic                  is_ctrl;
  logic [2:0]            reg_fld;
  logic                  mem_form;

  assign reg_fld  = i_instr.modrm[5:3];
  assign mem_form = (i_instr.modrm[7:6] != 2'h3);

  // ==========================================================
  // Opcode decode
  always_comb begin
    dec_op = ntcd_pkg::NTCD_IGNORE;
    unique case (i_instr.group)
      `NTCD_GRP_001: begin
        if (mem_form) begin
          if (reg_fld == `NTCD_REG_LDCW) begin
            dec_op = ntcd_pkg::NTCD_LDCW;
          end else if (reg_fld == `NTCD_REG_STENV) begin
            dec_op = ntcd_pkg::NTCD_STENV;
          end else if (reg_fld == `NTCD_REG_LDENV) begin
            dec_op = ntcd_pkg::NTCD_LDENV;
          end
        end else begin
          unique case (i_instr.modrm)
            `NTCD_OP_COS:    dec_op = ntcd_pkg::NTCD_COS;
            `NTCD_OP_PTAN:   dec_op = ntcd_pkg::NTCD_PTAN;
            `NTCD_OP_PATAN:  dec_op = ntcd_pkg::NTCD_PATAN;
            `NTCD_OP_SIN:    dec_op = ntcd_pkg::NTCD_SIN;
            `NTCD_OP_SINCOS: dec_op = ntcd_pkg::NTCD_SINCOS;
            `NTCD_OP_INCSP:  dec_op = ntcd_pkg::NTCD_INCSP;
            `NTCD_OP_DECSP:  dec_op = ntcd_pkg::NTCD_DECSP;
            `NTCD_OP_NOP:    dec_op = ntcd_pkg::NTCD_NOP;
            default:         dec_op = ntcd_pkg::NTCD_IGNORE;
          endcase
        end
      end
      `NTCD_GRP_011: begin
        unique case (i_instr.modrm)
          `NTCD_OP_INIT:  dec_op = ntcd_pkg::NTCD_INIT;
          `NTCD_OP_SETPM: dec_op = ntcd_pkg::NTCD_SETPM;
          `NTCD_OP_RSTPM: dec_op = ntcd_pkg::NTCD_RSTPM;
          `NTCD_OP_CLEX:  dec_op = ntcd_pkg::NTCD_CLEX;
          // Legacy enable/disable decode to nothing at all
          `NTCD_OP_IENA:  dec_op = ntcd_pkg::NTCD_IGNORE;
          `NTCD_OP_IDIS:  dec_op = ntcd_pkg::NTCD_IGNORE;
          default:        dec_op = ntcd_pkg::NTCD_IGNORE;
        endcase
      end
      `NTCD_GRP_101: begin
        if (mem_form && reg_fld == `NTCD_REG_RSTOR) begin
          dec_op = ntcd_pkg::NTCD_RSTOR;
        end else if (mem_form && reg_fld == `NTCD_REG_SAVE) begin
          dec_op = ntcd_pkg::NTCD_SAVE;
        end
      end
      `NTCD_GRP_111: begin
        if (i_instr.modrm == `NTCD_OP_STSWAX) begin
          dec_op = ntcd_pkg::NTCD_STSWAX;
        end
      end
      default: dec_op = ntcd_pkg::NTCD_IGNORE;
    endcase
  end

  // Control ops the host may issue while busy; they are dropped
  // here unless we are idle, since we take one instruction at a time.
  assign is_ctrl = (dec_op == ntcd_pkg::NTCD_INIT) ||
                   (dec_op == ntcd_pkg::NTCD_CLEX) ||
                   (dec_op == ntcd_pkg::NTCD_SETPM) ||
                   (dec_op == ntcd_pkg::NTCD_RSTPM);

  // Ignored opcodes are never accepted, so no state moves
  assign accept = i_instr_valid && (state_r == ntcd_pkg::NTCD_ST_IDLE)
                  && (dec_op != ntcd_pkg::NTCD_IGNORE);

  // Rom looks at the offered op, so its count stands when load_r does
  ntcd_cycle_rom u_rom (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_op      (dec_op),
    .i_reduce  (i_instr.far_reduce),
    .o_cycles  (rom_cycles)
  );

  // ==========================================================
  // Sequencer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r  <= ntcd_pkg::NTCD_ST_IDLE;
      load_r   <= 1'b0;
      cnt_r    <= 10'h000;
    end else begin
      load_r <= accept;
      unique case (state_r)
        ntcd_pkg::NTCD_ST_IDLE: begin
          if (accept) begin
            state_r  <= ntcd_pkg::NTCD_ST_EXEC;
          end
        end
        ntcd_pkg::NTCD_ST_EXEC: begin
          // Rom count was registered at the accepting edge
          if (load_r) begin
            cnt_r <= rom_cycles - 10'h002;
          end else if (cnt_r == 10'h000) begin
            state_r <= ntcd_pkg::NTCD_ST_DONE;
          end else begin
            cnt_r <= cnt_r - 10'h001;
          end
        end
        ntcd_pkg::NTCD_ST_DONE: begin
          state_r <= ntcd_pkg::NTCD_ST_IDLE;
        end
        default: state_r <= ntcd_pkg::NTCD_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Host-facing outputs
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_op   <= ntcd_pkg::NTCD_NONE;
    end else begin
      // Busy covers accept through the last execution cycle
      o_busy <= accept || (state_r == ntcd_pkg::NTCD_ST_EXEC &&
                !(cnt_r == 10'h000 && !load_r));
      o_done <= (state_r == ntcd_pkg::NTCD_ST_EXEC) && !load_r &&
                (cnt_r == 10'h000);
      if (accept) begin
        o_op <= dec_op;
      end
    end
  end

  // ==========================================================
  // Operating mode; real-address after reset
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_protected <= 1'b0;
    end else if (accept && dec_op == ntcd_pkg::NTCD_SETPM) begin
      o_protected <= 1'b1;
    end else if (accept && dec_op == ntcd_pkg::NTCD_RSTPM) begin
      o_protected <= 1'b0;
    end
  end

  // ==========================================================
  // Exception line, driven straight to the host
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_error <= 1'b0;
    end else if (i_exc_raise) begin
      // Raise beats a same-cycle clear so no event is lost
      o_error <= 1'b1;
    end else if (accept && (dec_op == ntcd_pkg::NTCD_CLEX ||
                 dec_op == ntcd_pkg::NTCD_INIT)) begin
      o_error <= 1'b0;
    end
  end

  // ==========================================================
  // Stack pointer
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_stack_ptr <= 3'h0;
    end else if (accept) begin
      if (dec_op == ntcd_pkg::NTCD_INCSP) begin
        o_stack_ptr <= o_stack_ptr + 3'h1;
      end else if (dec_op == ntcd_pkg::NTCD_DECSP) begin
        o_stack_ptr <= o_stack_ptr - 3'h1;
      end else if (dec_op == ntcd_pkg::NTCD_INIT) begin
        o_stack_ptr <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Instruction pointer image; control ops leave it alone
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ptr <= '0;
    end else if (accept && !is_ctrl &&
                 dec_op != ntcd_pkg::NTCD_STSWAX &&
                 dec_op != ntcd_pkg::NTCD_NOP) begin
      // Host supplies the first prefix byte's address
      o_ptr.addr <= i_instr.addr;
      if (o_protected) begin
        o_ptr.opcode   <= 11'h000;
        o_ptr.op_valid <= 1'b0;
      end else begin
        o_ptr.opcode   <= {i_instr.group, i_instr.modrm};
        o_ptr.op_valid <= 1'b1;
      end
    end
  end

endmodule

//--- shared/ntcd_cfg.svh
`ifndef NTCD_CFG_SVH
`define NTCD_CFG_SVH

// ============================================================
// Clock
`define NTCD_CLK_PERIOD_NS 25

// ============================================================
// Escape groups (low three bits of the escape byte)
`define NTCD_GRP_001 3'h1
`define NTCD_GRP_011 3'h3
`define NTCD_GRP_101 3'h5
`define NTCD_GRP_111 3'h7

// ============================================================
// Second-byte encodings
`define NTCD_OP_COS    8'hFF
`define NTCD_OP_PTAN   8'hF2
`define NTCD_OP_PATAN  8'hF3
`define NTCD_OP_SIN    8'hFE
`define NTCD_OP_SINCOS 8'hFB
`define NTCD_OP_INIT   8'hE3
`define NTCD_OP_SETPM  8'hE4
`define NTCD_OP_RSTPM  8'hF4
`define NTCD_OP_STSWAX 8'hE0
`define NTCD_OP_CLEX   8'hE2
`define NTCD_OP_INCSP  8'hF7
`define NTCD_OP_DECSP  8'hF6
`define NTCD_OP_NOP    8'hD0
`define NTCD_OP_IENA   8'hE0
`define NTCD_OP_IDIS   8'hE1

// ============================================================
// ModR/M reg field
`define NTCD_REG_LDCW  3'h5
`define NTCD_REG_STENV 3'h6
`define NTCD_REG_LDENV 3'h4
`define NTCD_REG_RSTOR 3'h4
`define NTCD_REG_SAVE  3'h6

// ============================================================
// Execution cycle counts (clock counts, upper end of ranges)
`define NTCD_CYC_COS    10'd779
`define NTCD_CYC_PTAN   10'd504
`define NTCD_CYC_PATAN  10'd494
`define NTCD_CYC_SIN    10'd778
`define NTCD_CYC_SINCOS 10'd816
`define NTCD_CYC_REDUCE 10'd78
`define NTCD_CYC_INIT   10'd25
`define NTCD_CYC_PM     10'd12
`define NTCD_CYC_STSW   10'd18
`define NTCD_CYC_LDCW   10'd33
`define NTCD_CYC_CLEX   10'd8
`define NTCD_CYC_STENV  10'd193
`define NTCD_CYC_LDENV  10'd85
`define NTCD_CYC_RSTOR  10'd396
`define NTCD_CYC_SAVE   10'd522
`define NTCD_CYC_INCSP  10'd28
`define NTCD_CYC_DECSP  10'd29
`define NTCD_CYC_NOP    10'd19

`endif

//--- shared/ntcd_pkg.sv
package ntcd_pkg;

  typedef enum logic [4:0] {
    NTCD_NONE   = 5'h00,
    NTCD_COS    = 5'h01,
    NTCD_PTAN   = 5'h02,
    NTCD_PATAN  = 5'h03,
    NTCD_SIN    = 5'h04,
    NTCD_SINCOS = 5'h05,
    NTCD_INIT   = 5'h06,
    NTCD_SETPM  = 5'h07,
    NTCD_RSTPM  = 5'h08,
    NTCD_STSWAX = 5'h09,
    NTCD_LDCW   = 5'h0A,
    NTCD_CLEX   = 5'h0B,
    NTCD_STENV  = 5'h0C,
    NTCD_LDENV  = 5'h0D,
    NTCD_RSTOR  = 5'h0E,
    NTCD_SAVE   = 5'h0F,
    NTCD_INCSP  = 5'h10,
    NTCD_DECSP  = 5'h11,
    NTCD_NOP    = 5'h12,
    NTCD_IGNORE = 5'h13
  } ntcd_op_e;

  typedef enum logic [2:0] {
    NTCD_ST_IDLE = 3'b001,
    NTCD_ST_EXEC = 3'b010,
    NTCD_ST_DONE = 3'b100
  } ntcd_state_e;

  // Instruction as delivered by the host
  typedef struct packed {
    logic [2:0]  group;
    logic [7:0]  modrm;
    logic [19:0] addr;
    logic        far_reduce;
  } ntcd_instr_s;

  // Saved instruction pointer image
  typedef struct packed {
    logic [19:0] addr;
    logic [10:0] opcode;
    logic        op_valid;
  } ntcd_ptr_s;

endpackage

//--- src/ntcd_cycle_rom.sv
`timescale 1ns/1ps
`include "ntcd_cfg.svh"

module ntcd_cycle_rom (
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire ntcd_pkg::ntcd_op_e i_op,
  input  wire logic               i_reduce,
  output logic [9:0]              o_cycles
);

  logic [9:0] base;

  always_comb begin
    unique case (i_op)
      ntcd_pkg::NTCD_COS:    base = `NTCD_CYC_COS;
      ntcd_pkg::NTCD_PTAN:   base = `NTCD_CYC_PTAN;
      ntcd_pkg::NTCD_PATAN:  base = `NTCD_CYC_PATAN;
      ntcd_pkg::NTCD_SIN:    base = `NTCD_CYC_SIN;
      ntcd_pkg::NTCD_SINCOS: base = `NTCD_CYC_SINCOS;
      ntcd_pkg::NTCD_INIT:   base = `NTCD_CYC_INIT;
      ntcd_pkg::NTCD_SETPM:  base = `NTCD_CYC_PM;
      ntcd_pkg::NTCD_RSTPM:  base = `NTCD_CYC_PM;
      ntcd_pkg::NTCD_STSWAX: base = `NTCD_CYC_STSW;
      ntcd_pkg::NTCD_LDCW:   base = `NTCD_CYC_LDCW;
      ntcd_pkg::NTCD_CLEX:   base = `NTCD_CYC_CLEX;
      ntcd_pkg::NTCD_STENV:  base = `NTCD_CYC_STENV;
      ntcd_pkg::NTCD_LDENV:  base = `NTCD_CYC_LDENV;
      ntcd_pkg::NTCD_RSTOR:  base = `NTCD_CYC_RSTOR;
      ntcd_pkg::NTCD_SAVE:   base = `NTCD_CYC_SAVE;
      ntcd_pkg::NTCD_INCSP:  base = `NTCD_CYC_INCSP;
      ntcd_pkg::NTCD_DECSP:  base = `NTCD_CYC_DECSP;
      ntcd_pkg::NTCD_NOP:    base = `NTCD_CYC_NOP;
      default:               base = 10'h001;
    endcase
  end

  // ==========================================================
  // Registered read; sine, cosine and sine-cosine add the range-reduction budget
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cycles <= 10'h001;
    end else if (i_reduce && (i_op == ntcd_pkg::NTCD_COS ||
                 i_op == ntcd_pkg::NTCD_SIN ||
                 i_op == ntcd_pkg::NTCD_SINCOS)) begin
      o_cycles <= base + `NTCD_CYC_REDUCE;
    end else begin
      o_cycles <= base;
    end
  end

endmodule

//--- verif/ntcd_decode_chk.sv
`timescale 1ns/1ps
module ntcd_decode_chk (
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset,
  input wire logic                  i_instr_valid,
  input wire ntcd_pkg::ntcd_instr_s i_instr,
  input wire logic                  i_exc_raise,
  input wire logic                  o_busy,
  input wire logic                  o_error,
  input wire logic                  o_protected,
  input wire logic                  o_done,
  input wire ntcd_pkg::ntcd_op_e    o_op,
  input wire ntcd_pkg::ntcd_ptr_s   o_ptr,
  input wire logic [2:0]            o_stack_ptr
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // ============================================================
  // Sequencing
  property p_busy_cause; $rose(o_busy) |-> $past(i_instr_valid); endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose with no offer");
  property p_done_end; o_done |-> !o_busy && $past(o_busy); endproperty
  a_done_end: assert property (p_done_end)
    else $error("done not right after busy");
  property p_done_pulse; o_done |=> !o_done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  // Shortest op is eight cycles, longest far sine and cosine 894
  property p_busy_min; $rose(o_busy) |-> o_busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy shorter than eight cycles");
  property p_busy_max; $rose(o_busy) |-> ##[8:894] !o_busy; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy longer than 894 cycles");
  // ============================================================
  // Error line, legacy opcodes, pointer image
  property p_err_set; i_exc_raise |=> o_error; endproperty
  a_err_set: assert property (p_err_set)
    else $error("exception not on error line");
  property p_err_hold;
    o_error && !o_busy && !o_done && !i_instr_valid |=> o_error;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error dropped while idle");
  property p_legacy;
    !o_busy && !o_done && i_instr_valid && i_instr.group == 3'h3 &&
    i_instr.modrm[7:1] == 7'h70 |=> !o_busy && $stable(o_op) &&
    $stable(o_protected) && $stable(o_stack_ptr);
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy opcode changed state");
  property p_ptr_pm;
    o_protected && $past(o_protected) && $changed(o_ptr) |->
    o_ptr.op_valid == 1'b0 && o_ptr.opcode == 11'h000;
  endproperty
  a_ptr_pm: assert property (p_ptr_pm)
    else $error("opcode saved in protected mode");
  c_done: cover property (o_done);
  c_clear: cover property ($fell(o_error));
  c_pm: cover property ($rose(o_protected));
endmodule

bind ntcd_decode ntcd_decode_chk u_chk (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
  .i_exc_raise(i_exc_raise), .o_busy(o_busy), .o_error(o_error),
  .o_protected(o_protected), .o_done(o_done), .o_op(o_op),
  .o_ptr(o_ptr), .o_stack_ptr(o_stack_ptr));

//--- verif/ntcd_host_model.sv
`timescale 1ns/1ps
// ============================================================
// Host side: offers one escape at a time
module ntcd_host_model (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire logic                  i_busy,
  input  wire logic                  i_done,
  input  wire logic                  i_go,
  input  wire logic                  i_nowait,
  input  wire ntcd_pkg::ntcd_instr_s i_cmd,
  output logic                       o_valid,
  output ntcd_pkg::ntcd_instr_s      o_instr
);
  logic                  pend_r;
  logic                  nw_r;
  ntcd_pkg::ntcd_instr_s cmd_r;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_r <= 1'b0;
      nw_r <= 1'b0;
      cmd_r <= '0;
      o_valid <= 1'b0;
      o_instr <= '0;
    end else if (i_go) begin
      pend_r <= 1'b1;
      nw_r <= i_nowait;
      cmd_r <= i_cmd;
      o_valid <= 1'b0;
      o_instr <= ~o_instr;
    end else if (pend_r && (nw_r || (!i_busy && !i_done))) begin
      // No-wait form models control escapes that skip the busy test
      pend_r <= 1'b0;
      o_valid <= 1'b1;
      o_instr <= cmd_r;
    end else begin
      o_valid <= 1'b0;
      // Released lines toggle so a stale value is never taken as fresh
      o_instr <= ~o_instr;
    end
  end
endmodule

//--- verif/ntcd_decode_tb_top.sv
`timescale 1ns/1ps
module ntcd_decode_tb_top;
  typedef struct packed {
    logic [2:0]         g;
    logic [7:0]         m;
    ntcd_pkg::ntcd_op_e o;
    logic [9:0]         n;
    logic               c;
    logic               f;
  } ntcd_row_s;
  typedef struct packed {
    ntcd_pkg::ntcd_op_e o;
    logic [9:0]         n;
  } ntcd_exp_s;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  exc = 1'b0;
  logic                  go = 1'b0;
  logic                  nw = 1'b0;
  logic                  vld;
  logic                  busy;
  logic                  err;
  logic                  prot;
  logic                  done;
  logic [2:0]            sp;
  logic [9:0]            bc = 10'h000;
  logic [15:0]           rnd = 16'h0041;
  int                    n_errors = 0;
  int                    checks_done = 0;
  ntcd_pkg::ntcd_instr_s cmd = '0;
  ntcd_pkg::ntcd_instr_s ins;
  ntcd_pkg::ntcd_op_e    op;
  ntcd_pkg::ntcd_ptr_s   ptr;
  ntcd_exp_s             ex;
  ntcd_exp_s             q[$];

  always #12.5 clk = ~clk;

  ntcd_decode dut (.i_ref_clk(clk), .i_reset(rst), .i_instr_valid(vld),
    .i_instr(ins), .i_exc_raise(exc), .o_busy(busy), .o_error(err),
    .o_protected(prot), .o_done(done), .o_op(op), .o_ptr(ptr),
    .o_stack_ptr(sp));
  ntcd_host_model host (.i_ref_clk(clk), .i_reset(rst), .i_busy(busy),
    .i_done(done), .i_go(go), .i_nowait(nw), .i_cmd(cmd), .o_valid(vld),
    .o_instr(ins));

  // ============================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic ntcd_row_s row(input logic [4:0] i);
    case (i)
      5'h00: return '{3'h1, 8'hFF, ntcd_pkg::NTCD_COS, 10'h30B, 1'b1, 1'b1};
      5'h01: return '{3'h1, 8'hF2, ntcd_pkg::NTCD_PTAN, 10'h1F8, 1'b1, 1'b0};
      5'h02: return '{3'h1, 8'hF3, ntcd_pkg::NTCD_PATAN, 10'h1EE, 1'b1, 1'b0};
      5'h03: return '{3'h1, 8'hFE, ntcd_pkg::NTCD_SIN, 10'h30A, 1'b1, 1'b1};
      5'h04: return '{3'h1, 8'hFB, ntcd_pkg::NTCD_SINCOS, 10'h330, 1'b1, 1'b1};
      5'h05: return '{3'h3, 8'hE3, ntcd_pkg::NTCD_INIT, 10'h019, 1'b0, 1'b0};
      5'h06: return '{3'h3, 8'hE4, ntcd_pkg::NTCD_SETPM, 10'h00C, 1'b0, 1'b0};
      5'h07: return '{3'h3, 8'hF4, ntcd_pkg::NTCD_RSTPM, 10'h00C, 1'b0, 1'b0};
      5'h08: return '{3'h7, 8'hE0, ntcd_pkg::NTCD_STSWAX, 10'h012, 1'b0, 1'b0};
      5'h09: return '{3'h1, 8'h28, ntcd_pkg::NTCD_LDCW, 10'h021, 1'b0, 1'b0};
      5'h0A: return '{3'h3, 8'hE2, ntcd_pkg::NTCD_CLEX, 10'h008, 1'b0, 1'b0};
      5'h0B: return '{3'h1, 8'h30, ntcd_pkg::NTCD_STENV, 10'h0C1, 1'b0, 1'b0};
      5'h0C: return '{3'h1, 8'h20, ntcd_pkg::NTCD_LDENV, 10'h055, 1'b0, 1'b0};
      5'h0D: return '{3'h5, 8'h20, ntcd_pkg::NTCD_RSTOR, 10'h18C, 1'b0, 1'b0};
      5'h0E: return '{3'h5, 8'h30, ntcd_pkg::NTCD_SAVE, 10'h20A, 1'b0, 1'b0};
      5'h0F: return '{3'h1, 8'hF7, ntcd_pkg::NTCD_INCSP, 10'h01C, 1'b0, 1'b0};
      5'h10: return '{3'h1, 8'hF6, ntcd_pkg::NTCD_DECSP, 10'h01D, 1'b0, 1'b0};
      5'h12: return '{3'h3, 8'hE0, ntcd_pkg::NTCD_NONE, 10'h000, 1'b0, 1'b0};
      5'h13: return '{3'h3, 8'hE1, ntcd_pkg::NTCD_NONE, 10'h000, 1'b0, 1'b0};
      default: return '{3'h1, 8'hD0, ntcd_pkg::NTCD_NOP, 10'h013, 1'b0, 1'b0};
    endcase
  endfunction
  task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_op(input ntcd_pkg::ntcd_op_e got,
                        input ntcd_pkg::ntcd_op_e exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask
  // Offers one escape; a no-wait offer is not expected to be taken
  task automatic issue(input logic [4:0] i, input logic far, input logic w);
    ntcd_row_s r;
    r = row(i);
    rnd = lfsr(rnd);
    @(posedge clk);
    cmd <= '{r.g, r.m, {rnd[3:0], rnd}, far};
    nw <= w;
    go <= 1'b1;
    if (!w) q.push_back('{r.o, r.n + ((r.f && far) ? 10'h04E : 10'h000)});
    @(posedge clk);
    go <= 1'b0;
    if (!w) begin
      for (int k = 0; k < 1200 && done !== 1'b1; k++) @(negedge clk);
      cmp_val({19'h00000, done}, 20'h00001);
      if (r.c && prot === 1'b1)
        cmp_val({8'h00, ptr.opcode, ptr.op_valid}, 20'h00000);
      else if (r.c)
        cmp_val(ptr.addr, {rnd[3:0], rnd});
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ============================================================
  // Result watcher: busy length and op at each done pulse
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        cmp_val(20'h00000, 20'h00001);
      end else begin
        ex = q.pop_front();
        cmp_op(op, ex.o);
        cmp_val({10'h000, bc}, {10'h000, ex.n});
      end
      bc <= 10'h000;
    end else if (busy === 1'b1) begin
      bc <= bc + 10'h001;
    end
  end

  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end

  // ============================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 18; i++) issue(i[4:0], p[0], 1'b0);
    $display("test 1 done");
    issue(5'h05, 1'b0, 1'b0);
    issue(5'h10, 1'b0, 1'b0);
    cmp_val({17'h00000, sp}, 20'h00007);
    issue(5'h0F, 1'b0, 1'b0);
    issue(5'h0F, 1'b0, 1'b0);
    cmp_val({17'h00000, sp}, 20'h00001);
    issue(5'h06, 1'b0, 1'b0);
    cmp_val({19'h00000, prot}, 20'h00001);
    issue(5'h03, 1'b1, 1'b0);
    issue(5'h07, 1'b0, 1'b0);
    cmp_val({19'h00000, prot}, 20'h00000);
    $display("test 2 done");
    @(posedge clk);
    exc <= 1'b1;
    @(posedge clk);
    exc <= 1'b0;
    @(negedge clk);
    cmp_val({19'h00000, err}, 20'h00001);
    issue(5'h11, 1'b0, 1'b0);
    cmp_val({19'h00000, err}, 20'h00001);
    issue(5'h0A, 1'b0, 1'b0);
    cmp_val({19'h00000, err}, 20'h00000);
    $display("test 3 done");
    issue(5'h12, 1'b0, 1'b1);
    issue(5'h13, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    cmp_val({19'h00000, busy}, 20'h00000);
    cmp_op(op, ntcd_pkg::NTCD_CLEX);
    cmp_val({17'h00000, sp}, 20'h00001);
    fork
      issue(5'h11, 1'b0, 1'b0);
      begin
        repeat (8) @(posedge clk);
        issue(5'h0A, 1'b0, 1'b1);
      end
    join
    repeat (4) @(negedge clk);
    cmp_val({19'h00000, busy}, 20'h00000);
    cmp_op(op, ntcd_pkg::NTCD_NOP);
    $display("test 4 done");
    end_of_test();
  end
endmodule
